// [lfs_apb_slave.sv]
// Purpose: APB register port with one control and one status register.
// Assumes: APB4 signalling with byte strobes.
// Notes: Every access takes one wait-free access phase; unmapped addresses answer an error.
`timescale 1ns/100ps
`include "lfs_map.svh"

module lfs_apb_slave (
	// Clock, reset and enable.
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// APB.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [`LFS_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Block side.
	input wire logic [31:0] status_in,
	output logic startup_mask_out
);

	logic setup;
	logic wr_ctrl;

	assign setup = psel_in && !penable_in;
	assign wr_ctrl = psel_in && penable_in && pready_out && pwrite_in &&
		(paddr_in == `LFS_CTRL_OFS) && pstrb_in[0];

	// ==========================================================================
	// Read data and answer, captured in the setup cycle.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			pready_out <= 1'h0;
			prdata_out <= 32'h0;
			pslverr_out <= 1'h0;
		end else if (ce_in) begin
			pready_out <= setup;
			if (setup) begin
				if (paddr_in == `LFS_CTRL_OFS) begin
					prdata_out <= {31'h0, startup_mask_out};
					pslverr_out <= 1'h0;
				end else if (paddr_in == `LFS_STATUS_OFS) begin
					prdata_out <= pwrite_in ? 32'h0 : status_in;
					pslverr_out <= 1'h0;
				end else begin
					prdata_out <= 32'h0;
					pslverr_out <= 1'h1;
				end
			end
		end
	end

	// ==========================================================================
	// Control register.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			startup_mask_out <= `LFS_CTRL_RESET;
		end else if (ce_in && wr_ctrl) begin
			startup_mask_out <= pwdata_in[`LFS_CTRL_MASK_BIT];
		end
	end

endmodule

// [lfs_fault_supervisor.sv]
// Purpose: Fault supervisor of a two-string LED backlight driver.
// Assumes: Detector flags and host pins are synchronous to clk_sys_in.
// Notes: Power stage controls are registered from the next state.
`timescale 1ns/100ps
`include "lfs_map.svh"

module lfs_fault_supervisor #(
	parameter int unsigned SHUTDOWN_CYC = `LFS_SHUTDOWN_LOW_CYCLES,
	parameter int unsigned GRACE_CYC = `LFS_GRACE_CYCLES,
	parameter int unsigned UVLO_CYC = `LFS_UVLO_CYCLES
) (
	// Clock, reset and enable.
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// APB register port.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [`LFS_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Host pins.
	input wire logic dim_en_in,
	input wire logic freq_set_sync_pin_in,
	// Detector flags.
	input wire lfs_pkg::lfs_detect_s detect_in,
	// Power stage and flag.
	output lfs_pkg::lfs_drive_s drive_out,
	output logic fault_n_out
);

	lfs_pkg::lfs_state_e state_reg;
	lfs_pkg::lfs_state_e state_next;
	lfs_pkg::lfs_drive_s drive_next;
	logic [2:0] lat_reg;
	logic [2:0] lat_next;
	logic [2:0] lat_set;
	logic [1:0] pend_reg;
	logic [1:0] pend_next;
	logic [1:0] open_rm_reg;
	logic [1:0] open_rm_next;
	logic [1:0] removed_next;
	logic skip_reg;
	logic skip_next;
	logic enlow_q;
	logic synclow_q;
	logic uvlo_q;
	logic grace_q;
	logic startup_mask;
	logic grace_cond;
	logic lat_clr;
	logic auto_off;
	logic fault_next;
	logic stay_run;
	logic [31:0] status;

	// ==========================================================================
	// Register port.
	assign status = {23'h0, uvlo_q, open_rm_reg, ~fault_n_out, lat_reg, state_reg};

	lfs_apb_slave u_apb (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.pwdata_in(pwdata_in),
		.pstrb_in(pstrb_in),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.status_in(status),
		.startup_mask_out(startup_mask)
	);

	// ==========================================================================
	// Hold timers.
	lfs_hold_timer #(.LIMIT(SHUTDOWN_CYC)) u_enlow (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.cond_in(!dim_en_in),
		.expired_out(enlow_q)
	);

	lfs_hold_timer #(.LIMIT(`LFS_SYNC_LOW_CYCLES)) u_synclow (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.cond_in(!freq_set_sync_pin_in),
		.expired_out(synclow_q)
	);

	lfs_hold_timer #(.LIMIT(UVLO_CYC)) u_uvlo (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.cond_in(detect_in.undervoltage_threshold),
		.expired_out(uvlo_q)
	);

	lfs_hold_timer #(.LIMIT(GRACE_CYC)) u_grace (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.cond_in(grace_cond),
		.expired_out(grace_q)
	);

	// ==========================================================================
	// Fault latches.
	assign grace_cond = detect_in.sense_1x && !detect_in.sense_2x &&
		(state_reg == lfs_pkg::LFS_ST_RUN ||
		(state_reg == lfs_pkg::LFS_ST_STARTUP && !startup_mask));
	assign lat_set = (state_reg == lfs_pkg::LFS_ST_SHUTDOWN) ? 3'h0 :
		{detect_in.secondary_overvoltage_level,
		detect_in.sense_2x || grace_q,
		detect_in.secondary_switch_limit};
	assign lat_clr = enlow_q || uvlo_q;
	assign lat_next = lat_set | (lat_clr ? 3'h0 : lat_reg);
	assign auto_off = detect_in.overtemp || detect_in.freq_set_sync_pin_over ||
		synclow_q || uvlo_q;
	assign skip_next = detect_in.primary_switch_limit ||
		(skip_reg && !detect_in.switch_cycle_start);
	assign fault_next = (|lat_next) || grace_cond ||
		(detect_in.freq_set_sync_pin_over && state_reg != lfs_pkg::LFS_ST_SHUTDOWN);
	assign stay_run = (state_reg == lfs_pkg::LFS_ST_RUN) && (state_next == lfs_pkg::LFS_ST_RUN);

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			lat_reg <= 3'h0;
			skip_reg <= 1'h0;
		end else if (ce_in) begin
			lat_reg <= lat_next;
			skip_reg <= skip_next;
		end
	end

	// ==========================================================================
	// Supervisor state.
	always_comb begin
		state_next = state_reg;
		if (|lat_next) begin
			state_next = lfs_pkg::LFS_ST_LATCHED;
		end else if (lat_clr) begin
			state_next = lfs_pkg::LFS_ST_SHUTDOWN;
		end else begin
			case (state_reg)
				lfs_pkg::LFS_ST_SHUTDOWN: begin
					if (dim_en_in) begin
						state_next = lfs_pkg::LFS_ST_STARTUP;
					end
				end
				lfs_pkg::LFS_ST_STARTUP: begin
					if (!auto_off && detect_in.sink_short_threshold == 2'h0) begin
						state_next = lfs_pkg::LFS_ST_RUN;
					end
				end
				lfs_pkg::LFS_ST_RUN: begin
					if (auto_off) begin
						state_next = lfs_pkg::LFS_ST_STARTUP;
					end
				end
				default: begin
					state_next = lfs_pkg::LFS_ST_SHUTDOWN;
				end
			endcase
		end
	end

	// ==========================================================================
	// Per-string open and short handling.
	for (genvar i = 0; i < 2; i++) begin : g_sink
		assign open_rm_next[i] = (state_next == lfs_pkg::LFS_ST_RUN) &&
			(open_rm_reg[i] || (pend_reg[i] && detect_in.overvoltage_threshold));
		assign pend_next[i] = (state_next == lfs_pkg::LFS_ST_RUN) && !open_rm_next[i] &&
			(pend_reg[i] || detect_in.sink_open[i]);
		assign removed_next[i] = detect_in.sink_short_threshold[i] || open_rm_next[i];

		always_ff @(posedge clk_sys_in) begin
			if (srst_in) begin
				pend_reg[i] <= 1'h0;
				open_rm_reg[i] <= 1'h0;
			end else if (ce_in) begin
				pend_reg[i] <= pend_next[i];
				open_rm_reg[i] <= open_rm_next[i];
			end
		end
	end

	// ==========================================================================
	// Power stage controls.
	always_comb begin
		drive_next = '0;
		case (state_next)
			lfs_pkg::LFS_ST_STARTUP: begin
				drive_next.disconnect_on = !auto_off;
			end
			lfs_pkg::LFS_ST_RUN: begin
				drive_next.disconnect_on = 1'h1;
				drive_next.boost_en = !skip_next && !detect_in.overvoltage_threshold &&
					!detect_in.current_set_pin_over;
				drive_next.sink_en = {2{dim_en_in && !detect_in.current_set_pin_over}} &
					~removed_next;
				drive_next.raise_output = |pend_next;
			end
			lfs_pkg::LFS_ST_SHUTDOWN: begin
				drive_next.low_power = 1'h1;
			end
			default: begin
				drive_next = '0;
			end
		endcase
		drive_next.soft_start = (state_reg == lfs_pkg::LFS_ST_STARTUP) &&
			(state_next == lfs_pkg::LFS_ST_RUN);
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			state_reg <= lfs_pkg::LFS_ST_SHUTDOWN;
			drive_out <= '0;
			fault_n_out <= 1'h1;
		end else if (ce_in) begin
			state_reg <= state_next;
			drive_out <= drive_next;
			fault_n_out <= !fault_next;
		end
	end

	// ==========================================================================
	// Checks.
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	chk_shutdown_clear: assert property (ce_in && enlow_q && lat_set == 3'h0 |=>
		state_reg == lfs_pkg::LFS_ST_SHUTDOWN && lat_reg == 3'h0)
		else $error("Shutdown did not clear the fault latches.");
	chk_shutdown_sinks: assert property (state_reg == lfs_pkg::LFS_ST_SHUTDOWN |->
		drive_out.sink_en == 2'h0 && (drive_out.low_power || $past(srst_in)))
		else $error("Sinks enabled during shutdown.");
	chk_shutdown_wake: assert property (ce_in && state_reg == lfs_pkg::LFS_ST_SHUTDOWN &&
		!dim_en_in |=> state_reg == lfs_pkg::LFS_ST_SHUTDOWN)
		else $error("Woke from shutdown with enable low.");
	chk_primary_skip: assert property (ce_in && stay_run && detect_in.primary_switch_limit |=>
		!drive_out.boost_en && drive_out.disconnect_on)
		else $error("Primary limit did not skip the switching cycle.");
	chk_secsw_latch: assert property (ce_in && detect_in.secondary_switch_limit &&
		state_reg != lfs_pkg::LFS_ST_SHUTDOWN |=> state_reg == lfs_pkg::LFS_ST_LATCHED &&
		!drive_out.boost_en && !drive_out.disconnect_on && drive_out.sink_en == 2'h0 &&
		!fault_n_out)
		else $error("Secondary switch limit did not latch off.");
	chk_latch_hold: assert property (ce_in && state_reg == lfs_pkg::LFS_ST_LATCHED &&
		!lat_clr |=> state_reg == lfs_pkg::LFS_ST_LATCHED && !fault_n_out)
		else $error("Latched fault released without shutdown.");
	chk_in2x_latch: assert property (ce_in && detect_in.sense_2x &&
		state_reg != lfs_pkg::LFS_ST_SHUTDOWN |=> lat_reg[1] && !drive_out.disconnect_on &&
		!drive_out.boost_en && !fault_n_out)
		else $error("Twice threshold did not latch off.");
	chk_grace_flag: assert property (ce_in && stay_run && detect_in.sense_1x &&
		!detect_in.sense_2x |=> !fault_n_out && drive_out.disconnect_on)
		else $error("One-times overcurrent not flagged.");
	chk_secovp_latch: assert property (ce_in && detect_in.secondary_overvoltage_level &&
		state_reg != lfs_pkg::LFS_ST_SHUTDOWN |=> lat_reg[2] && drive_out.sink_en == 2'h0)
		else $error("Secondary overvoltage did not latch off.");
	chk_short_hold: assert property (state_reg == lfs_pkg::LFS_ST_STARTUP |->
		!drive_out.boost_en && drive_out.sink_en == 2'h0)
		else $error("Boost or sinks active before soft-start.");
	chk_current_set_pin_stop: assert property (ce_in && stay_run && detect_in.current_set_pin_over |=>
		!drive_out.boost_en && drive_out.sink_en == 2'h0 && drive_out.disconnect_on &&
		$stable(lat_reg))
		else $error("Current-set fault did not stop boost and sinks.");
	chk_fset_off: assert property (ce_in && detect_in.freq_set_sync_pin_over &&
		state_reg != lfs_pkg::LFS_ST_SHUTDOWN |=> !drive_out.disconnect_on && !fault_n_out)
		else $error("Sync pin fault did not turn off.");
	chk_ovp_boost: assert property (ce_in && stay_run && detect_in.overvoltage_threshold |=>
		!drive_out.boost_en && drive_out.disconnect_on)
		else $error("Boost switched above overvoltage threshold.");
	chk_overtemp_off: assert property (ce_in && detect_in.overtemp |=>
		!drive_out.disconnect_on && drive_out.sink_en == 2'h0 && !drive_out.boost_en)
		else $error("Overtemperature did not turn off.");
	chk_uvlo_reset: assert property (ce_in && uvlo_q && lat_set == 3'h0 |=>
		lat_reg == 3'h0 && state_reg == lfs_pkg::LFS_ST_SHUTDOWN)
		else $error("Undervoltage did not reset latched faults.");
	chk_sync_fast: assert property (ce_in && synclow_q |=>
		!drive_out.disconnect_on && drive_out.sink_en == 2'h0 && !drive_out.boost_en)
		else $error("Sync pin low did not stop the driver.");
	chk_grace_expiry: assert property (ce_in && grace_q &&
		state_reg != lfs_pkg::LFS_ST_SHUTDOWN |=> lat_reg[1] && !fault_n_out)
		else $error("Grace expiry did not latch off.");

	cov_latched: cover property (state_reg == lfs_pkg::LFS_ST_LATCHED);
	cov_soft_start: cover property (drive_out.soft_start);
	cov_string_removed: cover property (open_rm_reg != 2'h0);
	cov_latch_released: cover property (state_reg == lfs_pkg::LFS_ST_LATCHED ##1
		state_reg == lfs_pkg::LFS_ST_SHUTDOWN);

endmodule

// [lfs_fault_supervisor_tb.sv]
// Purpose: Self-checking bench of the fault supervisor.
// Assumes: Shortened shutdown, grace and undervoltage counts.
// Notes: Power stage and fault_n outputs are sampled on the falling edge; APB read data after the rising edge.
`timescale 1ns/100ps

module lfs_fault_supervisor_tb;
	// ==========================================================================
	// Signals.
	localparam int SD = 40;
	localparam int GR = 30;
	localparam int UV = 20;
	logic clk_sys_in = 1'h0;
	logic srst_in = 1'h1;
	logic ce = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic dim_en;
	logic sync;
	logic [14:0] det = 15'h0;
	logic [6:0] drv;
	logic fault_n;
	logic [31:0] rdata;
	logic rerr;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int lat[3] = '{14, 10, 9};
	int idx[6] = '{7, 6, 8, 5, 2, 3};
	logic [3:0] pwx[6] = '{4'h4, 4'h0, 4'h7, 4'h0, 4'hE, 4'hD};
	logic fnx[6] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};

	initial begin
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	lfs_host_model host (.clk_sys_in(clk_sys_in), .dim_en_out(dim_en), .sync_out(sync));

	lfs_fault_supervisor #(.SHUTDOWN_CYC(SD), .GRACE_CYC(GR), .UVLO_CYC(UV)) dut (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .dim_en_in(dim_en), .freq_set_sync_pin_in(sync),
		.detect_in(det), .drive_out(drv), .fault_n_out(fault_n)
	);

	// ==========================================================================
	// Tasks.
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles > 20000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask

	task automatic pw(input logic [3:0] p);
		@(negedge clk_sys_in);
		chk("power", {28'h0, p}, {28'h0, drv[6:3]});
	endtask

	task automatic out_is(input logic [3:0] p, input logic fn);
		pw(p);
		chk("fault_n", {31'h0, fn}, {31'h0, fault_n});
	endtask

	task automatic set(input int i, input logic v);
		@(posedge clk_sys_in);
		det[i] <= v;
	endtask

	task automatic pulse(input int i);
		set(i, 1'h1);
		set(i, 1'h0);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_sys_in);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk_sys_in);
		penable <= 1'h1;
		@(posedge clk_sys_in);
		while (pready !== 1'h1) @(posedge clk_sys_in);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'h0, a, 32'h0, 4'h0);
		chk("rdata", d, rdata);
		chk("pslverr", {31'h0, e}, {31'h0, rerr});
	endtask

	task automatic st(input logic [1:0] s);
		apb(1'h0, 12'h004, 32'h0, 4'h0);
		chk("state", {30'h0, s}, {30'h0, rdata[1:0]});
	endtask

	task automatic go_down();
		host.set_en(1'h0);
		cyc(SD + 8);
		out_is(4'h0, 1'h1);
		chk("low_power", 32'h1, {31'h0, drv[0]});
		st(2'h0);
	endtask

	// ==========================================================================
	// Scenarios.
	initial begin
		cyc(6);
		srst_in <= 1'h0;
		cyc(8);
		st(2'h2);
		out_is(4'hF, 1'h1);
		rd(12'h000, 32'h1, 1'h0);
		apb(1'h1, 12'h000, 32'h0, 4'h0);
		rd(12'h000, 32'h1, 1'h0);
		apb(1'h1, 12'h000, 32'h0, 4'h1);
		rd(12'h000, 32'h0, 1'h0);
		rd(12'h008, 32'h0, 1'h1);
		apb(1'h1, 12'h000, 32'h1, 4'h1);
		pulse(13);
		out_is(4'h7, 1'h1);
		cyc(3);
		out_is(4'h7, 1'h1);
		pulse(12);
		cyc(2);
		out_is(4'hF, 1'h1);
		for (int k = 0; k < 3; k++) begin
			pulse(lat[k]);
			cyc(1);
			out_is(4'h0, 1'h0);
			st(2'h3);
			host.set_en(1'h0);
			cyc(SD - 8);
			out_is(4'h0, 1'h0);
			cyc(16);
			out_is(4'h0, 1'h1);
			host.set_en(1'h1);
			cyc(4);
			out_is(4'hF, 1'h1);
		end
		set(11, 1'h1);
		cyc(1);
		out_is(4'hF, 1'h0);
		set(11, 1'h0);
		cyc(1);
		out_is(4'hF, 1'h1);
		set(11, 1'h1);
		cyc(GR + 4);
		out_is(4'h0, 1'h0);
		set(11, 1'h0);
		go_down();
		set(2, 1'h1);
		host.set_en(1'h1);
		cyc(4);
		out_is(4'h4, 1'h1);
		st(2'h1);
		set(11, 1'h1);
		cyc(2);
		out_is(4'h4, 1'h1);
		apb(1'h1, 12'h000, 32'h0, 4'h1);
		cyc(1);
		out_is(4'h4, 1'h0);
		set(11, 1'h0);
		apb(1'h1, 12'h000, 32'h1, 4'h1);
		set(2, 1'h0);
		cyc(1);
		@(negedge clk_sys_in);
		chk("soft_start", 32'h1, {31'h0, drv[1]});
		cyc(3);
		out_is(4'hF, 1'h1);
		for (int k = 0; k < 6; k++) begin
			set(idx[k], 1'h1);
			cyc(2);
			out_is(pwx[k], fnx[k]);
			set(idx[k], 1'h0);
			cyc(6);
			out_is(4'hF, 1'h1);
		end
		set(4, 1'h1);
		cyc(UV - 4);
		set(4, 1'h0);
		cyc(2);
		out_is(4'hF, 1'h1);
		pulse(14);
		set(4, 1'h1);
		cyc(UV + 4);
		out_is(4'h0, 1'h1);
		set(4, 1'h0);
		cyc(6);
		out_is(4'hF, 1'h1);
		fork
			host.sync_low(1800);
			begin
				cyc(1700);
				pw(4'hF);
				cyc(60);
				pw(4'h0);
			end
		join
		cyc(6);
		pw(4'hF);
		@(posedge clk_sys_in);
		ce <= 1'h0;
		set(5, 1'h1);
		cyc(3);
		pw(4'hF);
		@(posedge clk_sys_in);
		ce <= 1'h1;
		cyc(1);
		pw(4'h0);
		set(5, 1'h0);
		cyc(6);
		pw(4'hF);
		set(0, 1'h1);
		cyc(2);
		@(negedge clk_sys_in);
		chk("raise", 32'h1, {31'h0, drv[2]});
		set(8, 1'h1);
		cyc(2);
		@(negedge clk_sys_in);
		chk("sinks", 32'h2, {30'h0, drv[4:3]});
		chk("raise", 32'h0, {31'h0, drv[2]});
		set(8, 1'h0);
		set(0, 1'h0);
		cyc(2);
		pw(4'hE);
		report_and_stop();
	end
endmodule

// [lfs_hold_timer.sv]
// Purpose: Flags a condition that has held for more than LIMIT clock cycles.
// Assumes: The condition is synchronous to the clock.
// Notes: The flag rises after LIMIT + 1 consecutive enabled cycles of the condition.
`timescale 1ns/100ps
`include "lfs_map.svh"

module lfs_hold_timer #(
	parameter int unsigned LIMIT = 16
) (
	// Clock, reset and enable.
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// Condition and result.
	input wire logic cond_in,
	output logic expired_out
);

	localparam int unsigned WIDTH = $clog2(LIMIT + 1);

	logic [WIDTH-1:0] cnt_reg;

	// ==========================================================================
	// Saturating counter of the condition.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			cnt_reg <= '0;
			expired_out <= 1'h0;
		end else if (ce_in) begin
			if (!cond_in) begin
				cnt_reg <= '0;
			end else if (cnt_reg != WIDTH'(LIMIT)) begin
				cnt_reg <= cnt_reg + 1'h1;
			end
			expired_out <= cond_in && (cnt_reg == WIDTH'(LIMIT));
		end
	end

endmodule

// [lfs_host_model.sv]
// Purpose: Host controller model driving the enable and sync pins.
// Assumes: Pins change by non-blocking assignment after a rising edge.
// Notes: Both pins idle high.
`timescale 1ns/100ps

module lfs_host_model (
	// Clock.
	input wire logic clk_sys_in,
	// Host pins.
	output logic dim_en_out,
	output logic sync_out
);
	// ==========================================================================
	// Pin drivers.
	initial begin
		dim_en_out = 1'h1;
		sync_out = 1'h1;
	end

	task automatic set_en(input logic v);
		@(posedge clk_sys_in);
		dim_en_out <= v;
	endtask

	// Fast shutdown holds the sync pin low for the given number of cycles.
	task automatic sync_low(input int n);
		@(posedge clk_sys_in);
		sync_out <= 1'h0;
		repeat (n) @(posedge clk_sys_in);
		sync_out <= 1'h1;
	endtask
endmodule

// [lfs_map.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the fault supervisor.
// Assumes: The system clock runs at 250 MHz.
// Notes: Sync-low and undervoltage times are kept in microseconds and their cycle counts derive from them; shutdown and grace are given in cycles.
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH

// ==========================================================================
// Clock and timing.
`define LFS_CLK_PERIOD_PS 4000
`define LFS_SHUTDOWN_LOW_CYCLES 32750
`define LFS_GRACE_CYCLES 10000
`define LFS_SYNC_LOW_TIME_US 7
`define LFS_SYNC_LOW_CYCLES \
	((`LFS_SYNC_LOW_TIME_US * 1000000 + `LFS_CLK_PERIOD_PS - 1) / `LFS_CLK_PERIOD_PS)
`define LFS_UVLO_TIME_US 50
`define LFS_UVLO_CYCLES \
	((`LFS_UVLO_TIME_US * 1000000 + `LFS_CLK_PERIOD_PS - 1) / `LFS_CLK_PERIOD_PS)

// ==========================================================================
// Register map.
`define LFS_ADDR_W 12
`define LFS_CTRL_OFS 12'h000
`define LFS_STATUS_OFS 12'h004
`define LFS_CTRL_MASK_BIT 0
`define LFS_CTRL_RESET 1'h1
`define LFS_STATUS_STATE_LSB 0
`define LFS_STATUS_LATCH_LSB 2
`define LFS_STATUS_FAULT_BIT 5
`define LFS_STATUS_REMOVED_LSB 6
`define LFS_STATUS_UVLO_BIT 8

`endif

// [lfs_pkg.sv]
// Purpose: Types shared by the fault supervisor files.
// Assumes: Nothing beyond the map header.
// Notes: Carriers are packed structs.
package lfs_pkg;

	// ==========================================================================
	// Supervisor states.
	typedef enum logic [1:0] {
		LFS_ST_SHUTDOWN = 2'h0,
		LFS_ST_STARTUP = 2'h1,
		LFS_ST_RUN = 2'h2,
		LFS_ST_LATCHED = 2'h3
	} lfs_state_e;

	// ==========================================================================
	// Analog detector flags, all active high.
	typedef struct packed {
		logic secondary_switch_limit;
		logic primary_switch_limit;
		logic switch_cycle_start;
		logic sense_1x;
		logic sense_2x;
		logic secondary_overvoltage_level;
		logic overvoltage_threshold;
		logic current_set_pin_over;
		logic freq_set_sync_pin_over;
		logic overtemp;
		logic undervoltage_threshold;
		logic [1:0] sink_short_threshold;
		logic [1:0] sink_open;
	} lfs_detect_s;

	// ==========================================================================
	// Power stage controls.
	typedef struct packed {
		logic boost_en;
		logic disconnect_on;
		logic [1:0] sink_en;
		logic raise_output;
		logic soft_start;
		logic low_power;
	} lfs_drive_s;

endpackage
